/* common/dcam_regs.vh */
// Purpose: register offsets, field positions, reset values and counts for the alarm monitor
// Assumes: 16-bit registers reached by a 7-bit byte address on a simple register port
// Notes: offsets follow the device's register map layout
`ifndef DCAM_REGS_VH
`define DCAM_REGS_VH

// ===========================================================
// register addresses (byte address, even)
`define DCAM_ADDR_W 7
`define DCAM_OFF_ONE_THRESHOLD 7'h26
`define DCAM_OFF_TWO_THRESHOLD 7'h28
`define DCAM_OFF_ONE_SAMPLE_COUNT 7'h2a
`define DCAM_OFF_TWO_SAMPLE_COUNT 7'h2c
`define DCAM_OFF_ALARM_CONTROL 7'h2e
`define DCAM_OFF_DIAG_STATUS 7'h3c

// ===========================================================
// reset values
`define DCAM_RST_REG 16'h0000

// ===========================================================
// threshold fields
`define DCAM_THR_DIR_BIT 15
`define DCAM_THR_LVL_MSB 13

// ===========================================================
// sample count fields
`define DCAM_SMP_MSB 7

// ===========================================================
// control fields
`define DCAM_CTL_SRC2_MSB 15
`define DCAM_CTL_SRC2_LSB 12
`define DCAM_CTL_SRC1_MSB 11
`define DCAM_CTL_SRC1_LSB 8
`define DCAM_CTL_ROC2_BIT 7
`define DCAM_CTL_ROC1_BIT 6
`define DCAM_CTL_FILT_BIT 4
`define DCAM_CTL_OUT_EN_BIT 2
`define DCAM_CTL_OUT_POL_BIT 1
`define DCAM_CTL_OUT_SEL_BIT 0

// ===========================================================
// source codes
`define DCAM_SRC_DISABLE 4'h0
`define DCAM_SRC_SUPPLY 4'h1
`define DCAM_SRC_AUX 4'hb

// ===========================================================
// diagnostic status flag positions
`define DCAM_DIAG_ALM2_BIT 9
`define DCAM_DIAG_ALM1_BIT 8

// ===========================================================
// sample history depth
`define DCAM_HIST_DEPTH 256

`endif

/* rtl/dcam_channel.v */
// Purpose: one alarm channel: source pick, static or rate-of-change compare
// Assumes: sample stream arrives as one-cycle strobe with 12 sources of 16 bits each
// Notes: history ring holds the last samples of the selected source
`timescale 1ns/1ps
`include "dcam_regs.vh"

module dcam_channel #(
    parameter DATA_W = 16,
    parameter DEPTH = `DCAM_HIST_DEPTH
)(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // sample stream
    input wire sample_stb_i,
    input wire [12*DATA_W-1:0] raw_bus_i,
    input wire [12*DATA_W-1:0] filt_bus_i,
    // configuration
    input wire [3:0] source_i,
    input wire roc_i,
    input wire filt_i,
    input wire [15:0] threshold_i,
    input wire [15:0] sample_count_i,
    // result
    output reg hit_o
);

// ===========================================================
// source selection
reg [DATA_W-1:0] cur_sample;
reg [12*DATA_W-1:0] sel_bus;
always @*
begin
    // filtered or unfiltered data
    sel_bus = filt_i ? filt_bus_i : raw_bus_i;
    cur_sample = {DATA_W{1'b0}};
    if (source_i <= `DCAM_SRC_AUX)
    begin
        cur_sample = sel_bus[source_i*DATA_W +: DATA_W];
    end
end

// ===========================================================
// history ring
reg [DATA_W-1:0] hist_mem [0:DEPTH-1];
reg [7:0] wr_ptr_reg;
reg [3:0] last_src_reg;
reg [8:0] fill_reg;
wire [7:0] count_eff;
wire [7:0] rd_ptr;
wire [DATA_W-1:0] old_sample;

assign count_eff = (sample_count_i[`DCAM_SMP_MSB:0] == 8'h00) ? 8'h01 :
    sample_count_i[`DCAM_SMP_MSB:0];
assign rd_ptr = wr_ptr_reg - count_eff;
assign old_sample = hist_mem[rd_ptr];

always @(posedge clk_i)
begin
    if (sample_stb_i)
    begin
        hist_mem[wr_ptr_reg] <= cur_sample;
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        wr_ptr_reg <= 8'h00;
        fill_reg <= 9'h000;
        last_src_reg <= 4'h0;
    end
    else if (sample_stb_i)
    begin
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
        last_src_reg <= source_i;
        if (last_src_reg != source_i)
        begin
            fill_reg <= 9'h001;
        end
        else if (fill_reg != 9'h100)
        begin
            fill_reg <= fill_reg + 9'h001;
        end
    end
end

// ===========================================================
// comparison
reg [DATA_W-1:0] cmp_val;
reg hit_next;
wire signed [DATA_W-1:0] cmp_s;
wire signed [DATA_W-1:0] lvl_s;
wire hist_ok;

assign cmp_s = cmp_val;
assign lvl_s = {{(DATA_W-13){threshold_i[`DCAM_THR_LVL_MSB]}},
    threshold_i[`DCAM_THR_LVL_MSB-1:0]};
assign hist_ok = (last_src_reg == source_i) && (fill_reg >= {1'b0, count_eff});

always @*
begin
    cmp_val = roc_i ? (cur_sample - old_sample) : cur_sample;
    hit_next = 1'b0;
    if ((source_i != `DCAM_SRC_DISABLE) && (source_i <= `DCAM_SRC_AUX) &&
        (!roc_i || hist_ok))
    begin
        if (threshold_i[`DCAM_THR_DIR_BIT])
        begin
            hit_next = (cmp_s > lvl_s);
        end
        else
        begin
            hit_next = (cmp_s < lvl_s);
        end
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        hit_o <= 1'b0;
    end
    else if (sample_stb_i)
    begin
        hit_o <= hit_next;
    end
end

endmodule // dcam_channel

/* rtl/dcam_alarm_monitor.v */
// Purpose: dual alarm monitor with register port, status flags and indicator pin
// Assumes: sensor sample stream and strobe come from logic on clk_i
// Notes: sample strobe marks each sample period set by the sample-period setting
`timescale 1ns/1ps
`include "dcam_regs.vh"

// How it works
// - two independent channels, own settings except shared filter bit 4
// - rate window equals count times period
// - threshold bit 15 picks direction
// - bits 13:0 level, bit 14 ignored
// - count bits 7:0, zero means one
// - control 15:12 second channel source
// - control 11:8 first channel source
// - bits 7/6 choose rate or static
// - bit 4 selects filtered data
// - bit 2 enables indicator pin
// - bit 1 sets indicator polarity
// - bit 0 picks second I/O line
// - all registers reset to zero
// - status bits 9/8 show alarms
// - status read clears, sets again
module dcam_alarm_monitor #(
    parameter DATA_W = 16,
    parameter DEPTH = `DCAM_HIST_DEPTH
)(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // register port
    input wire [`DCAM_ADDR_W-1:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    // sample stream
    input wire sample_stb_i,
    input wire [12*DATA_W-1:0] raw_bus_i,
    input wire [12*DATA_W-1:0] filt_bus_i,
    // status
    output wire alarm_one_o,
    output wire alarm_two_o,
    // digital io lines
    output reg digital_io_line_one_o,
    output reg digital_io_line_one_oe_o,
    output reg digital_io_line_two_o,
    output reg digital_io_line_two_oe_o
);

// ===========================================================
// registers
reg [15:0] one_threshold_reg;
reg [15:0] two_threshold_reg;
reg [15:0] one_count_reg;
reg [15:0] two_count_reg;
reg [15:0] control_reg;
reg [1:0] flags_reg;
reg [1:0] flags_next;
wire hit_one;
wire hit_two;
wire diag_rd;
wire [5:0] reg_sel;

// ===========================================================
// address decode, one bit per register
function [5:0] reg_decode;
    input [`DCAM_ADDR_W-1:0] addr;
    begin
        case (addr)
            `DCAM_OFF_ONE_THRESHOLD: reg_decode = 6'h01;
            `DCAM_OFF_TWO_THRESHOLD: reg_decode = 6'h02;
            `DCAM_OFF_ONE_SAMPLE_COUNT: reg_decode = 6'h04;
            `DCAM_OFF_TWO_SAMPLE_COUNT: reg_decode = 6'h08;
            `DCAM_OFF_ALARM_CONTROL: reg_decode = 6'h10;
            `DCAM_OFF_DIAG_STATUS: reg_decode = 6'h20;
            default: reg_decode = 6'h00;
        endcase
    end
endfunction

// ===========================================================
// status word from the two flags
function [15:0] diag_word;
    input [1:0] flags;
    begin
        diag_word = `DCAM_RST_REG;
        diag_word[`DCAM_DIAG_ALM2_BIT] = flags[1];
        diag_word[`DCAM_DIAG_ALM1_BIT] = flags[0];
    end
endfunction

// unknown addresses select nothing
assign reg_sel = reg_decode(reg_addr_i);
assign diag_rd = reg_rd_i && reg_sel[5];

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        one_threshold_reg <= `DCAM_RST_REG;
        two_threshold_reg <= `DCAM_RST_REG;
        one_count_reg <= `DCAM_RST_REG;
        two_count_reg <= `DCAM_RST_REG;
        control_reg <= `DCAM_RST_REG;
    end
    else if (reg_wr_i)
    begin
        if (reg_sel[0])
        begin
            one_threshold_reg <= reg_wdata_i;
        end
        if (reg_sel[1])
        begin
            two_threshold_reg <= reg_wdata_i;
        end
        if (reg_sel[2])
        begin
            one_count_reg <= {8'h00, reg_wdata_i[`DCAM_SMP_MSB:0]};
        end
        if (reg_sel[3])
        begin
            two_count_reg <= {8'h00, reg_wdata_i[`DCAM_SMP_MSB:0]};
        end
        if (reg_sel[4])
        begin
            control_reg <= reg_wdata_i;
        end
    end
end

// ===========================================================
// read data
reg [15:0] rdata_next;
always @*
begin
    rdata_next = reg_rdata_o;
    if (reg_rd_i)
    begin
        case (reg_sel)
            6'h01: rdata_next = one_threshold_reg;
            6'h02: rdata_next = two_threshold_reg;
            6'h04: rdata_next = one_count_reg;
            6'h08: rdata_next = two_count_reg;
            6'h10: rdata_next = control_reg;
            6'h20: rdata_next = diag_word(flags_reg);
            default: rdata_next = `DCAM_RST_REG;
        endcase
    end
end

// read data holds until the next read
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        reg_rdata_o <= `DCAM_RST_REG;
    end
    else
    begin
        reg_rdata_o <= rdata_next;
    end
end

// ===========================================================
// channels
// two independent channels
dcam_channel #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH)
) u_chan_one (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_stb_i(sample_stb_i),
    .raw_bus_i(raw_bus_i),
    .filt_bus_i(filt_bus_i),
    .source_i(control_reg[`DCAM_CTL_SRC1_MSB:`DCAM_CTL_SRC1_LSB]),
    .roc_i(control_reg[`DCAM_CTL_ROC1_BIT]),
    .filt_i(control_reg[`DCAM_CTL_FILT_BIT]),
    .threshold_i(one_threshold_reg),
    .sample_count_i(one_count_reg),
    .hit_o(hit_one)
);

dcam_channel #(
    .DATA_W(DATA_W),
    .DEPTH(DEPTH)
) u_chan_two (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_stb_i(sample_stb_i),
    .raw_bus_i(raw_bus_i),
    .filt_bus_i(filt_bus_i),
    .source_i(control_reg[`DCAM_CTL_SRC2_MSB:`DCAM_CTL_SRC2_LSB]),
    .roc_i(control_reg[`DCAM_CTL_ROC2_BIT]),
    .filt_i(control_reg[`DCAM_CTL_FILT_BIT]),
    .threshold_i(two_threshold_reg),
    .sample_count_i(two_count_reg),
    .hit_o(hit_two)
);

// ===========================================================
// status flags
reg stb_d_reg;
always @*
begin
    flags_next = flags_reg;
    if (diag_rd)
    begin
        flags_next = 2'b00;
    end
    if (stb_d_reg)
    begin
        flags_next = flags_next | {hit_two, hit_one};
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        flags_reg <= 2'b00;
        stb_d_reg <= 1'b0;
    end
    else
    begin
        flags_reg <= flags_next;
        stb_d_reg <= sample_stb_i;
    end
end

// ===========================================================
// status outputs straight from the flags
assign alarm_one_o = flags_reg[0];
assign alarm_two_o = flags_reg[1];

// ===========================================================
// indicator pin
wire any_hit;
reg line_one_next;
reg line_one_oe_next;
reg line_two_next;
reg line_two_oe_next;
// indicator follows current hits, not the sticky flags
assign any_hit = hit_one | hit_two;

always @*
begin
    if (control_reg[`DCAM_CTL_OUT_POL_BIT])
    begin
        line_one_next = any_hit;
    end
    else
    begin
        line_one_next = ~any_hit;
    end
    line_two_next = line_one_next;
    line_one_oe_next = 1'b0;
    line_two_oe_next = 1'b0;
    if (control_reg[`DCAM_CTL_OUT_EN_BIT])
    begin
        if (control_reg[`DCAM_CTL_OUT_SEL_BIT])
        begin
            line_two_oe_next = 1'b1;
        end
        else
        begin
            line_one_oe_next = 1'b1;
        end
    end
end

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        digital_io_line_one_o <= 1'b0;
        digital_io_line_one_oe_o <= 1'b0;
        digital_io_line_two_o <= 1'b0;
        digital_io_line_two_oe_o <= 1'b0;
    end
    else
    begin
        digital_io_line_one_o <= line_one_next;
        digital_io_line_one_oe_o <= line_one_oe_next;
        digital_io_line_two_o <= line_two_next;
        digital_io_line_two_oe_o <= line_two_oe_next;
    end
end

endmodule // dcam_alarm_monitor

/* tb/dcam_sample_src.sv */
// Purpose: sensor sample stream source facing the alarm monitor
// Assumes: one value a request, placed in one source slot
// Notes: other slots carry zero; DLY sets how slowly it answers
`timescale 1ns/1ps
module dcam_sample_src #(
    parameter DLY = 1
)(
    // clock and request
    input wire clk_i,
    input wire fire_i,
    input wire [3:0] slot_i,
    input wire [15:0] raw_v_i,
    input wire [15:0] filt_v_i,
    // stream
    output reg stb_o,
    output reg [191:0] raw_o,
    output reg [191:0] filt_o
);
    initial
    begin
        stb_o = 1'b0;
        raw_o = 192'h0;
        filt_o = 192'h0;
    end
    // ==========================================
    // one strobe a request
    always @(posedge clk_i)
    begin
        if (fire_i)
        begin
            repeat (DLY) @(posedge clk_i);
            raw_o <= {176'h0, raw_v_i} << (16 * slot_i);
            filt_o <= {176'h0, filt_v_i} << (16 * slot_i);
            stb_o <= 1'b1;
            @(posedge clk_i);
            stb_o <= 1'b0;
        end
    end
endmodule // dcam_sample_src

/* tb/dcam_alarm_monitor_sva.sv */
// Purpose: port checks of the alarm monitor
// Assumes: flags and pins follow a strobe by two edges
// Notes: bound to every monitor instance
`timescale 1ns/1ps
`include "dcam_regs.vh"
module dcam_alarm_monitor_sva (
    // clock, reset, register port
    input wire clk_i,
    input wire rst_i,
    input wire [`DCAM_ADDR_W-1:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // stream, flags, pins
    input wire sample_stb_i,
    input wire alarm_one_o,
    input wire alarm_two_o,
    input wire digital_io_line_one_oe_o,
    input wire digital_io_line_two_o,
    input wire digital_io_line_two_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire diag_rd = reg_rd_i && reg_addr_i == `DCAM_OFF_DIAG_STATUS;
    wire ctl_wr = reg_wr_i && reg_addr_i == `DCAM_OFF_ALARM_CONTROL;
    wire known = reg_addr_i inside {`DCAM_OFF_ONE_THRESHOLD, `DCAM_OFF_TWO_THRESHOLD,
        `DCAM_OFF_ONE_SAMPLE_COUNT, `DCAM_OFF_TWO_SAMPLE_COUNT,
        `DCAM_OFF_ALARM_CONTROL, `DCAM_OFF_DIAG_STATUS};
    wire [1:0] oes = {digital_io_line_one_oe_o, digital_io_line_two_oe_o};
    sequence s_diag_rd; diag_rd; endsequence
    sequence s_any_fall; $fell(alarm_one_o) || $fell(alarm_two_o); endsequence
    // ==========================================
    // assertions
    property p_unmap; reg_rd_i && !known |=> reg_rdata_o == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rise1; $rose(alarm_one_o) |-> $past(sample_stb_i, 2); endproperty
    a_rise1: assert property (p_rise1) else $error("flag one rose off strobe");
    property p_rise2; $rose(alarm_two_o) |-> $past(sample_stb_i, 2); endproperty
    a_rise2: assert property (p_rise2) else $error("flag two rose off strobe");
    property p_fall; s_any_fall |-> $past(diag_rd); endproperty
    a_fall: assert property (p_fall) else $error("flag dropped without read");
    property p_clr; s_diag_rd |=> !(alarm_one_o || alarm_two_o) || $past(sample_stb_i, 2);
    endproperty
    a_clr: assert property (p_clr) else $error("flag kept after read");
    property p_oe_x; oes != 2'b11; endproperty
    a_oe_x: assert property (p_oe_x) else $error("both lines driven");
    property p_oe_chg; $changed(oes) |-> $past(ctl_wr, 2); endproperty
    a_oe_chg: assert property (p_oe_chg) else $error("enable moved off write");
    property p_pin;
        $changed(digital_io_line_two_o) && digital_io_line_two_oe_o
            |-> $past(sample_stb_i, 2) || $past(ctl_wr, 2);
    endproperty
    a_pin: assert property (p_pin) else $error("pin level moved unprompted");
    property p_rd_hold; !$past(reg_rd_i) |-> $stable(reg_rdata_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule // dcam_alarm_monitor_sva
bind dcam_alarm_monitor dcam_alarm_monitor_sva chk (.clk_i, .rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_stb_i, .alarm_one_o, .alarm_two_o,
    .digital_io_line_one_oe_o, .digital_io_line_two_o, .digital_io_line_two_oe_o);

/* tb/dcam_alarm_monitor_test.sv */
// Purpose: register-level test of the alarm monitor
// Assumes: stream model fires one sample a request
// Notes: expected values worked out from the field layout
`timescale 1ns/1ps
`include "dcam_regs.vh"
module dcam_alarm_monitor_test;
    localparam [6:0] DG = `DCAM_OFF_DIAG_STATUS;
    localparam [6:0] CT = `DCAM_OFF_ALARM_CONTROL;
    localparam [6:0] T1 = `DCAM_OFF_ONE_THRESHOLD;
    localparam [6:0] T2 = `DCAM_OFF_TWO_THRESHOLD;
    reg clk_i = 0, rst_i = 1, wr = 0, rd = 0, fire = 0;
    reg [6:0] addr = 0;
    reg [15:0] wd = 0, rv = 0, fv = 0;
    reg [3:0] slot = 0;
    wire stb, a1, a2, o1, e1, o2, e2;
    wire [15:0] rdat;
    wire [191:0] rb, fb;
    integer bad_count = 0, n_checks = 0, cyc = 0, k;
    dcam_sample_src #(.DLY(2)) src (.clk_i(clk_i), .fire_i(fire), .slot_i(slot),
        .raw_v_i(rv), .filt_v_i(fv), .stb_o(stb), .raw_o(rb), .filt_o(fb));
    dcam_alarm_monitor dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
        .sample_stb_i(stb), .raw_bus_i(rb), .filt_bus_i(fb), .alarm_one_o(a1),
        .alarm_two_o(a2), .digital_io_line_one_o(o1), .digital_io_line_one_oe_o(e1),
        .digital_io_line_two_o(o2), .digital_io_line_two_oe_o(e2));
    initial forever #5 clk_i = ~clk_i;
    // ==========================================
    // tasks
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input [15:0] g, input [15:0] e);
    begin
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task wrr(input [6:0] a, input [15:0] v);
    begin
        @(posedge clk_i);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    end
    endtask
    task rc(input [6:0] a, input [15:0] e);
    begin
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        @(negedge clk_i);
        chk(rdat, e);
    end
    endtask
    task smp(input [15:0] r, input [15:0] f);
    begin
        @(posedge clk_i);
        rv <= r;
        fv <= f;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    end
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    // ==========================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 'h26; k <= 'h2e; k = k + 2) rc(k[6:0], 16'h0000);
        rc(DG, 16'h0000);
        chk({12'h0, e1, e2, a1, a2}, 16'h0000);
        wrr(T1, 16'h9234);
        rc(T1, 16'h9234);
        wrr(`DCAM_OFF_ONE_SAMPLE_COUNT, 16'hffff);
        rc(`DCAM_OFF_ONE_SAMPLE_COUNT, 16'h00ff);
        wrr(7'h30, 16'h1234);
        rc(7'h30, 16'h0000);
        wrr(T1, 16'h8010);
        wrr(T2, 16'h8010);
        for (k = 0; k < 12; k = k + 1)
        begin
            slot <= k[3:0];
            wrr(CT, {k[3:0], k[3:0], 8'h00});
            smp(16'h0064, 16'h0000);
            rc(DG, (k == 0) ? 16'h0000 : 16'h0300);
        end
        slot <= 4'h5;
        wrr(T1, 16'h8096);
        wrr(T2, 16'h776a);
        wrr(CT, 16'h553f);
        smp(16'hf000, 16'h0100);
        chk({13'h0, e1, e2, o2}, 16'h0003);
        chk({14'h0, a1, a2}, 16'h0002);
        rc(DG, 16'h0100);
        smp(16'h0100, 16'hf000);
        chk({14'h0, a1, a2}, 16'h0001);
        rc(DG, 16'h0200);
        chk({14'h0, a1, a2}, 16'h0000);
        wrr(CT, 16'h5515);
        chk({13'h0, e1, e2, o2}, 16'h0002);
        wrr(CT, 16'h5514);
        chk({13'h0, e1, e2, o1}, 16'h0004);
        wrr(CT, 16'h5510);
        chk({14'h0, e1, e2}, 16'h0000);
        wrr(`DCAM_OFF_ONE_SAMPLE_COUNT, 16'h0002);
        wrr(T1, 16'h8010);
        wrr(CT, 16'h0640);
        slot <= 4'h6;
        for (k = 0; k < 3; k = k + 1) smp(16'h0000, 16'h0000);
        rc(DG, 16'h0000);
        smp(16'h0032, 16'h0000);
        rc(DG, 16'h0100);
        smp(16'h0032, 16'h0000);
        rc(DG, 16'h0100);
        smp(16'h0032, 16'h0000);
        rc(DG, 16'h0000);
        report_and_stop;
    end
endmodule // dcam_alarm_monitor_test
